// ===== dv/bthr_regs_chk.sv
// Assertion checker for the type 1 header register bank
module bthr_regs_chk
	import bthr_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        io_req_valid,
	input wire logic [31:0] io_req_addr,
	input wire logic        io_hit_valid_q,
	input wire logic        io_hit_q
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_both; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
	sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
	property p_wr_resp; s_wr_both |=> ##1 s_axi_bvalid; endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response late");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_ar_ref; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_ar_ref: assert property (p_ar_ref) else $error("read taken while busy");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_hdr;
		s_rd_take ##0 s_axi_araddr[11:2] == IDX_HEADER_TYPE |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0001;
	endproperty
	a_hdr: assert property (p_hdr) else $error("header type wrong");
	property p_bar;
		s_rd_take ##0 (s_axi_araddr[11:2] == IDX_BASE_ADDRESS_ZERO
			|| s_axi_araddr[11:2] == IDX_BASE_ADDRESS_ONE) |=> s_axi_rdata == 32'h0000_0000;
	endproperty
	a_bar: assert property (p_bar) else $error("base address not zero");
	property p_io_lat; io_req_valid |=> io_hit_valid_q; endproperty
	a_io_lat: assert property (p_io_lat) else $error("decode answer late");
	property p_io_quiet; !io_req_valid |=> !io_hit_valid_q && $stable(io_hit_q); endproperty
	a_io_quiet: assert property (p_io_quiet) else $error("decode moved unasked");
	property p_io_high; io_req_valid && io_req_addr[31:16] != 16'h0000 |=> !io_hit_q; endproperty
	a_io_high: assert property (p_io_high) else $error("high address hit");
endmodule
bind bthr_regs bthr_regs_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.io_req_valid, .io_req_addr, .io_hit_valid_q, .io_hit_q);

// ===== dv/testbench.sv
// Self-checking bench for the type 1 header register bank
module testbench
	import bthr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} bthr_row_t;
	logic        aclk, aresetn, io_req_valid, io_hit_valid_q, io_hit_q;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, io_req_addr, v;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [7:0]  downstream_bus_number_q, highest_bus_number_q;
	int          n_mismatch, cmp_count;
	bthr_row_t   rows [11] = '{'{12'h034, 32'h0000_00ff, 32'h0},
		'{12'h038, 32'h0000_00ff, 32'h1}, '{12'h03c, 32'h0000_00ff, 32'h0},
		'{12'h040, 32'hffff_ffff, 32'h0}, '{12'h050, 32'hffff_ffff, 32'h0},
		'{12'h060, 32'h0000_ff5a, 32'h5a}, '{12'h064, 32'h12, 32'h12},
		'{12'h068, 32'h34, 32'h34}, '{12'h070, 32'h20, 32'h20},
		'{12'h074, 32'h81, 32'h80}, '{12'h078, 32'h0000_ffff, 32'h0}};

	bthr_regs dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .io_req_valid, .io_req_addr, .io_hit_valid_q, .io_hit_q,
		.downstream_bus_number_q, .highest_bus_number_q);

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic end_of_test;
		$display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic tmo(input int n);
		if (n >= 40) begin
			n_mismatch++;
			$display("mismatch at %0t: no answer", $time);
			end_of_test();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] q);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
		end while (!s_axi_bvalid && n < 40);
		q = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
		tmo(n);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] q);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
		end while (!s_axi_rvalid && n < 40);
		d = s_axi_rdata;
		q = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
		tmo(n);
	endtask
	task automatic io(input logic [31:0] a, input logic e);
		io_req_addr <= a;
		io_req_valid <= 1'b1;
		@(posedge aclk);
		io_req_valid <= 1'b0;
		@(posedge aclk);
		chk({31'h0, io_hit_valid_q}, 32'h1);
		chk({31'h0, io_hit_q}, {31'h0, e});
	endtask
	task automatic rst;
		aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{aresetn, io_req_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_wdata, io_req_addr} = '0;
		n_mismatch = 0;
		cmp_count = 0;
		@(posedge aclk);
		rst();
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, r);
			chk({30'h0, r}, {30'h0, RESP_OKAY});
			rd(rows[i].a, v, r);
			chk(v, rows[i].e);
		end
		chk({24'h0, downstream_bus_number_q}, 32'h12);
		chk({24'h0, highest_bus_number_q}, 32'h34);
		$display("table test done");
		// Window now spans 0x2000 to 0x8fff
		io(32'h0000_1fff, 1'b0);
		io(32'h0000_2000, 1'b1);
		io(32'h0000_8fff, 1'b1);
		rd(12'h104, v, r);
		chk(v, 32'h2);
		io(32'h0000_9000, 1'b0);
		io(32'h0001_2000, 1'b0);
		$display("window test done");
		wr(12'h07c, 32'h1, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		rd(12'h07c, v, r);
		chk({r, v[29:0]}, {RESP_SLVERR, 30'h0});
		wr(12'h100, 32'h1, r);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
		rd(12'h100, v, r);
		chk(v, 32'h1);
		wr(12'h070, 32'h31, r);
		rd(12'h070, v, r);
		chk(v, 32'h30);
		rd(12'h074, v, r);
		chk(v, 32'h80);
		$display("lock test done");
		rst();
		rd(12'h070, v, r);
		chk(v, 32'hf1);
		rd(12'h074, v, r);
		chk(v, 32'h01);
		rd(12'h060, v, r);
		chk(v, 32'h0);
		chk({16'h0, downstream_bus_number_q, highest_bus_number_q}, 32'h0);
		io(32'h0000_f000, 1'b0);
		rd(12'h104, v, r);
		chk(v, 32'h1);
		$display("reset test done");
		end_of_test();
	end
endmodule

// ===== hdl/bthr_io_window.sv
// I/O window decode against base and limit fields
module bthr_io_window
	import bthr_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  io_base,
	input  wire logic [3:0]  io_limit,
	input  wire logic        req_valid,
	input  wire logic [31:0] req_addr,
	output logic             hit_valid_q,
	output logic             hit_q,
	output logic             empty
);

	logic in_range;

	// Upper address bits have no base/limit here, so must be zero
	assign empty    = (io_base > io_limit);                                     // [R15]
	assign in_range = (req_addr[31:16] == 16'h0000) &&
	                  (req_addr[15:12] >= io_base) &&
	                  (req_addr[15:12] <= io_limit);                           // [R15]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hit_valid_q <= 1'b0;
			hit_q       <= 1'b0;
		end else begin
			hit_valid_q <= req_valid;
			if (req_valid) begin
				hit_q <= in_range && !empty;                                // [R13]
			end
		end
	end

endmodule

// ===== hdl/bthr_pkg.sv
// Constants for the bridge type 1 header register bank
// Behaviour
// [R1] Header type reads fixed type 1 value
// [R2] Self-test register reads zero, read-only
// [R3] Both base address registers read zero
// [R4] Primary latency timer reads zero, read-only
// [R5] Secondary latency timer reads zero, read-only
// [R6] Upstream bus number RW, resets zero, inert
// [R7] Downstream bus number RW, resets zero
// [R8] Highest bus number RW, resets zero
// [R9] Base bit 0 width capability, lockable, resets one
// [R10] Limit bit 0 mirrors base capability bit
// [R11] Base bits 7:4 RW, reset all ones
// [R12] Limit bits 7:4 RW, reset zero
// [R13] Base and limit govern I/O forwarding
// [R14] Downstream status low byte reads zero
// [R15] Inside window when base <= A[15:12] <= limit; code also requires A[31:16] zero
package bthr_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int IDX_W  = 10;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_PRIMARY_LATENCY_TIMER   = 10'h00d;
	localparam logic [IDX_W-1:0] IDX_HEADER_TYPE             = 10'h00e;
	localparam logic [IDX_W-1:0] IDX_SELF_TEST               = 10'h00f;
	localparam logic [IDX_W-1:0] IDX_BASE_ADDRESS_ZERO       = 10'h010;
	localparam logic [IDX_W-1:0] IDX_BASE_ADDRESS_ONE        = 10'h014;
	localparam logic [IDX_W-1:0] IDX_UPSTREAM_BUS_NUMBER     = 10'h018;
	localparam logic [IDX_W-1:0] IDX_SECONDARY_LATENCY_TIMER = 10'h018;
	localparam logic [IDX_W-1:0] IDX_DOWNSTREAM_BUS_NUMBER   = 10'h019;
	localparam logic [IDX_W-1:0] IDX_HIGHEST_BUS_NUMBER      = 10'h01a;
	localparam logic [IDX_W-1:0] IDX_IO_WINDOW_BASE          = 10'h01c;
	localparam logic [IDX_W-1:0] IDX_IO_WINDOW_LIMIT         = 10'h01d;
	localparam logic [IDX_W-1:0] IDX_DOWNSTREAM_SIDE_STATUS  = 10'h01e;
	localparam logic [IDX_W-1:0] IDX_IO_CONTROL              = 10'h040;
	localparam logic [IDX_W-1:0] IDX_IO_DECODE_STATUS        = 10'h041;

	// Field positions
	localparam int SEC_LATENCY_LSB = 8;
	localparam int IO_CAP_BIT   = 0;
	localparam int IO_ADDR_LSB  = 4;
	localparam int IO_ADDR_MSB  = 7;
	localparam int IO_LOCK_BIT  = 0;
	localparam int IO_EMPTY_BIT = 0;
	localparam int IO_HIT_BIT   = 1;

	// Reset and fixed values
	localparam logic [7:0]  PRIMARY_LATENCY_TIMER_VAL   = 8'h00;
	localparam logic [7:0]  HEADER_TYPE_VAL             = 8'h01;
	localparam logic [7:0]  SELF_TEST_VAL               = 8'h00;
	localparam logic [31:0] BASE_ADDRESS_VAL            = 32'h0000_0000;
	localparam logic [7:0]  SECONDARY_LATENCY_TIMER_VAL = 8'h00;
	localparam logic [7:0]  BUS_NUMBER_RST              = 8'h00;
	localparam logic        IO_CAP_RST                  = 1'b1;
	localparam logic [3:0]  IO_BASE_RST                 = 4'hf;
	localparam logic [3:0]  IO_LIMIT_RST                = 4'h0;
	localparam logic [7:0]  DOWNSTREAM_STATUS_LOW_VAL   = 8'h00;
	localparam logic        IO_LOCK_RST                 = 1'b0;

	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

endpackage

// ===== hdl/bthr_regs.sv
// Type 1 header register bank with AXI4-Lite slave and I/O window decode
module bthr_regs
	import bthr_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// AXI4-Lite read data
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// I/O request decode
	input  wire logic              io_req_valid,
	input  wire logic [31:0]       io_req_addr,
	output logic                   io_hit_valid_q,
	output logic                   io_hit_q,
	// Bus numbers for the routing logic
	output logic [7:0]             downstream_bus_number_q,
	output logic [7:0]             highest_bus_number_q
);

	function automatic logic [IDX_W-1:0] addr_to_index(input logic [ADDR_W-1:0] a);
		addr_to_index = a[ADDR_W-1:2];
	endfunction

	function automatic logic index_mapped(input logic [IDX_W-1:0] i);
		case (i)
			IDX_PRIMARY_LATENCY_TIMER,
			IDX_HEADER_TYPE,
			IDX_SELF_TEST,
			IDX_BASE_ADDRESS_ZERO,
			IDX_BASE_ADDRESS_ONE,
			IDX_UPSTREAM_BUS_NUMBER,
			IDX_DOWNSTREAM_BUS_NUMBER,
			IDX_HIGHEST_BUS_NUMBER,
			IDX_IO_WINDOW_BASE,
			IDX_IO_WINDOW_LIMIT,
			IDX_DOWNSTREAM_SIDE_STATUS,
			IDX_IO_CONTROL,
			IDX_IO_DECODE_STATUS: index_mapped = 1'b1;
			default:              index_mapped = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	logic [7:0]        upstream_bus_number_q;
	logic              io_width_capability_q;
	logic [3:0]        io_window_base_q;
	logic [3:0]        io_window_limit_q;
	logic              io_lock_q;
	logic              window_empty;

	logic              aw_held_q;
	logic [IDX_W-1:0]  aw_idx_q;
	logic              w_held_q;
	logic [DATA_W-1:0] w_data_q;
	logic [3:0]        w_strb_q;
	logic              do_write;
	logic [DATA_W-1:0] rd_word;
	logic [IDX_W-1:0]  ar_idx;

	////////////////////////////////////////////////////////////////////////////////
	// Write channel capture, either order

	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
	assign do_write      = aw_held_q && w_held_q && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			aw_idx_q  <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q <= 1'b1;
			aw_idx_q  <= addr_to_index(s_axi_awaddr);
		end else if (do_write) begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_q <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (do_write) begin
			w_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= index_mapped(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Writable fields; read-only words ignore writes

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			upstream_bus_number_q <= BUS_NUMBER_RST;                          // [R6]
		end else if (do_write && aw_idx_q == IDX_UPSTREAM_BUS_NUMBER && w_strb_q[0]) begin
			upstream_bus_number_q <= w_data_q[7:0];                            // [R6]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			downstream_bus_number_q <= BUS_NUMBER_RST;                        // [R7]
		end else if (do_write && aw_idx_q == IDX_DOWNSTREAM_BUS_NUMBER && w_strb_q[0]) begin
			downstream_bus_number_q <= w_data_q[7:0];                          // [R7]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			highest_bus_number_q <= BUS_NUMBER_RST;                           // [R8]
		end else if (do_write && aw_idx_q == IDX_HIGHEST_BUS_NUMBER && w_strb_q[0]) begin
			highest_bus_number_q <= w_data_q[7:0];                             // [R8]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			io_lock_q <= IO_LOCK_RST;
		end else if (do_write && aw_idx_q == IDX_IO_CONTROL && w_strb_q[0]) begin
			io_lock_q <= w_data_q[IO_LOCK_BIT];
		end
	end

	// Capability bit changes only while unlocked
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			io_width_capability_q <= IO_CAP_RST;                              // [R9]
			io_window_base_q      <= IO_BASE_RST;                             // [R11]
		end else if (do_write && aw_idx_q == IDX_IO_WINDOW_BASE && w_strb_q[0]) begin
			if (!io_lock_q) begin
				io_width_capability_q <= w_data_q[IO_CAP_BIT];                 // [R9]
			end
			io_window_base_q <= w_data_q[IO_ADDR_MSB:IO_ADDR_LSB];             // [R11]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			io_window_limit_q <= IO_LIMIT_RST;                                // [R12]
		end else if (do_write && aw_idx_q == IDX_IO_WINDOW_LIMIT && w_strb_q[0]) begin
			io_window_limit_q <= w_data_q[IO_ADDR_MSB:IO_ADDR_LSB];            // [R12]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path

	assign s_axi_arready = !s_axi_rvalid;
	assign ar_idx        = addr_to_index(s_axi_araddr);

	always_comb begin
		rd_word = '0;
		case (ar_idx)
			IDX_PRIMARY_LATENCY_TIMER: rd_word[7:0] = PRIMARY_LATENCY_TIMER_VAL;  // [R4]
			IDX_HEADER_TYPE:           rd_word[7:0] = HEADER_TYPE_VAL;            // [R1]
			IDX_SELF_TEST:             rd_word[7:0] = SELF_TEST_VAL;              // [R2]
			IDX_BASE_ADDRESS_ZERO:     rd_word      = BASE_ADDRESS_VAL;           // [R3]
			IDX_BASE_ADDRESS_ONE:      rd_word      = BASE_ADDRESS_VAL;           // [R3]
			IDX_UPSTREAM_BUS_NUMBER: begin
				rd_word[7:0] = upstream_bus_number_q;                              // [R6]
				rd_word[SEC_LATENCY_LSB+:8] = SECONDARY_LATENCY_TIMER_VAL;         // [R5]
			end
			IDX_DOWNSTREAM_BUS_NUMBER: rd_word[7:0] = downstream_bus_number_q;    // [R7]
			IDX_HIGHEST_BUS_NUMBER:    rd_word[7:0] = highest_bus_number_q;       // [R8]
			IDX_IO_WINDOW_BASE: begin
				rd_word[IO_ADDR_MSB:IO_ADDR_LSB] = io_window_base_q;               // [R11]
				rd_word[IO_CAP_BIT] = io_width_capability_q;                       // [R9]
			end
			IDX_IO_WINDOW_LIMIT: begin
				rd_word[IO_ADDR_MSB:IO_ADDR_LSB] = io_window_limit_q;              // [R12]
				rd_word[IO_CAP_BIT] = io_width_capability_q;                       // [R10]
			end
			IDX_DOWNSTREAM_SIDE_STATUS: rd_word[7:0] = DOWNSTREAM_STATUS_LOW_VAL; // [R14]
			IDX_IO_CONTROL:             rd_word[IO_LOCK_BIT] = io_lock_q;
			IDX_IO_DECODE_STATUS: begin
				rd_word[IO_EMPTY_BIT] = window_empty;
				rd_word[IO_HIT_BIT]   = io_hit_q;
			end
			default:                    rd_word = '0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= index_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Forwarding decision for I/O requests

	bthr_io_window u_io_window (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.io_base     (io_window_base_q),
		.io_limit    (io_window_limit_q),
		.req_valid   (io_req_valid),
		.req_addr    (io_req_addr),
		.hit_valid_q (io_hit_valid_q),
		.hit_q       (io_hit_q),
		.empty       (window_empty)
	);                                                                          // [R13]

endmodule
